// [hdl/scan_shading_params.svh]
// timing counts, sizes, thresholds and reset values for the shading and streak erase path
// assumes one 20 MHz clock and a line of masked dummy pixels followed by image pixels
`ifndef SCAN_SHADING_PARAMS_SVH
`define SCAN_SHADING_PARAMS_SVH

// ---------------------------------------------------------------------------
// line geometry
// ---------------------------------------------------------------------------
`define DUMMY_PIX      9'd32
`define DUMMY_SHIFT    5
`define IMG_PIX        9'd256
`define LINE_PIX       9'd288
`define SHADE_LINES    3'd4
`define SHADE_SHIFT    2
`define FLUSH_CNT      4'd8

// ---------------------------------------------------------------------------
// shading levels
// ---------------------------------------------------------------------------
`define LAMP_MIN       8'h40
`define PIX_MAX        8'hFF

// ---------------------------------------------------------------------------
// streak erase widths and thresholds
// ---------------------------------------------------------------------------
`define WIN_LEN        8
`define WHITE_WIDTH    3'd6
`define DARK_WIDTH_LO  3'd4
`define DARK_WIDTH_HI  3'd6
`define WHITE_THR_1    9'h060
`define WHITE_THR_2    9'h030
`define DARK_THR_1     9'h070
`define DARK_THR_2     9'h048
`define DARK_THR_3     9'h028
`define LEVEL_RESET    2'h1

`endif

// [hdl/scan_shading_pkg.sv]
// types shared by the shading core and the streak erase stage
// assumes the constants header is included by each user
package scan_shading_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_ACQ,
      ST_SCAN
   } shade_state_e;

   typedef logic [1:0] level_t;
   typedef logic [7:0] pixel_t;

endpackage : scan_shading_pkg

// [hdl/streak_if.sv]
// link from the shading core to the streak erase stage
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface streak_if;
   import scan_shading_pkg::*;
   logic   in_valid;   // one slot shifts in
   pixel_t in_pix;
   logic   in_real;    // low for flush bubbles
   level_t white_lvl;
   level_t dark_lvl;
   logic   out_valid;
   pixel_t out_pix;

   modport src
   (
      output in_valid, in_pix, in_real, white_lvl, dark_lvl,
      input  out_valid, out_pix
   );
   modport erase
   (
      input  in_valid, in_pix, in_real, white_lvl, dark_lvl,
      output out_valid, out_pix
   );
endinterface : streak_if

// [hdl/streak_erase.sv]
// eight slot window that erases light and dark streaks of limited width
// assumes one slot per in_valid and flush bubbles after each line
`timescale 1ns/1ps
`include "scan_shading_params.svh"
module streak_erase
   import scan_shading_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   streak_if.erase  lk
);

   typedef struct packed
   {
      logic [`WIN_LEN-1:0][7:0] win;
      logic [`WIN_LEN-1:0]      real_q;
      logic                     ov;
      pixel_t                   op;
   } erase_s;

   erase_s s_q;
   erase_s s_d;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [8:0] wthr(input level_t l);
      wthr = (l == 2'd1) ? `WHITE_THR_1 : `WHITE_THR_2;
   endfunction : wthr

   function automatic logic [8:0] dthr(input level_t l);
      dthr = (l == 2'd1) ? `DARK_THR_1 : ((l == 2'd2) ? `DARK_THR_2 : `DARK_THR_3);
   endfunction : dthr

   // ------------------------------------------------------------------
   // window shift, detection and in-place repair
   // ------------------------------------------------------------------
   always_comb
   begin
      logic [8:0] lo;
      logic [8:0] hi;
      logic [8:0] avg;
      logic       w_hit;
      logic       d_hit;
      logic       done;
      logic [2:0] dmax;
      lo   = 9'h000;
      hi   = 9'h000;
      avg  = 9'h000;
      w_hit = 1'b0;
      d_hit = 1'b0;
      done = 1'b0;
      s_d = s_q;
      s_d.ov = 1'b0;
      dmax = (lk.dark_lvl == 2'd3) ? `DARK_WIDTH_HI : `DARK_WIDTH_LO;
      if (lk.in_valid)
      begin
         s_d.ov = s_q.real_q[`WIN_LEN-1];
         s_d.op = s_q.win[`WIN_LEN-1];
         for (int i = `WIN_LEN-1; i > 0; i--)
         begin
            s_d.win[i]    = s_q.win[i-1];
            s_d.real_q[i] = s_q.real_q[i-1];
         end
         s_d.win[0]    = lk.in_pix;
         s_d.real_q[0] = lk.in_real;
         for (int k = 1; k <= 6; k++)
         begin
            if (!done && s_d.real_q[0] && s_d.real_q[k+1])
            begin
               lo  = (s_d.win[0] < s_d.win[k+1]) ? {1'b0, s_d.win[0]} : {1'b0, s_d.win[k+1]};
               hi  = (s_d.win[0] > s_d.win[k+1]) ? {1'b0, s_d.win[0]} : {1'b0, s_d.win[k+1]};
               avg = ({1'b0, s_d.win[0]} + {1'b0, s_d.win[k+1]}) >> 1;
               w_hit = (lk.white_lvl != 2'd0) && (3'(k) <= `WHITE_WIDTH);
               d_hit = (lk.dark_lvl != 2'd0) && (3'(k) <= dmax);
               for (int j = 1; j <= k; j++)
               begin
                  if (!s_d.real_q[j] || ({1'b0, s_d.win[j]} <= hi + wthr(lk.white_lvl)))
                     w_hit = 1'b0;
                  if (!s_d.real_q[j] || ({1'b0, s_d.win[j]} + dthr(lk.dark_lvl) >= lo))
                     d_hit = 1'b0;
               end
               // hit: streak pixels replaced by the mean of the neighbour pair
               if (w_hit || d_hit)
               begin
                  done = 1'b1;
                  for (int j = 1; j <= k; j++)
                     s_d.win[j] = avg[7:0];
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign lk.out_valid = s_q.ov;
   assign lk.out_pix   = s_q.op;

endmodule : streak_erase

// [hdl/scan_shading_line_erase.sv]
// shading core: black level from masked dummies, white shading capture and
// correction, lamp fault check, and hand-off to the streak erase stage
// assumes pixels arrive synchronous to clk, one line_start pulse before each line
`timescale 1ns/1ps
`include "scan_shading_params.svh"
module scan_shading_line_erase
   import scan_shading_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   arst_n,
   input  wire logic   line_start,
   input  wire logic   pix_valid,
   input  wire pixel_t pix_data,
   input  wire logic   shade_start,
   input  wire logic   page_active,
   input  wire logic   setting_change,
   input  wire level_t white_streak_level,
   input  wire level_t dark_streak_level,
   output logic        out_valid,
   output pixel_t      out_pix,
   output logic        lamp_fault_code,
   output logic        shading_needed,
   output logic        shade_busy
);

   typedef struct packed
   {
      shade_state_e st;
      logic [8:0]   idx;
      logic         in_line;
      logic [12:0]  blk_sum;
      pixel_t       blk_avg;
      logic [2:0]   line_cnt;
      pixel_t       wmax;
      logic         lamp_fault;
      logic         shade_ok;
      logic         page_q;
      level_t       wlev;
      level_t       dlev;
      logic         sv;
      pixel_t       sp;
      logic         sreal;
      logic [3:0]   flush;
   } core_s;

   core_s s_q;
   core_s s_d;

   // per-pixel stores, no reset; white_mem is read in any page, even one that starts before the first capture
   logic [9:0] acc_mem   [0:255];
   logic [5:0] white_mem [0:255];

   logic       acc_we;
   logic [9:0] acc_wd;
   logic       white_we;
   logic [5:0] white_wd;
   logic [7:0] img_idx;

   streak_if lk ();

   // ------------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------------
   function automatic pixel_t sub_sat(input pixel_t a, input pixel_t b);
      sub_sat = (a > b) ? pixel_t'(a - b) : 8'h00;
   endfunction : sub_sat

   // gain correction on the six-bit scale; a dead shading cell acts as one
   function automatic pixel_t gain(input pixel_t v, input logic [5:0] w);
      logic [13:0] q;
      logic [5:0]  d;
      d = (w == 6'h00) ? 6'h01 : w;
      q = {v, 6'h00} / {8'h00, d};
      gain = (q > 14'(`PIX_MAX)) ? `PIX_MAX : q[7:0];
   endfunction : gain

   assign img_idx = 8'(s_q.idx - `DUMMY_PIX);

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   always_comb
   begin
      logic        is_dummy;
      logic        is_img;
      logic        last_pix;
      logic [9:0]  tot;
      pixel_t      wavg;
      pixel_t      nmax;
      logic [5:0]  wref;
      pixel_t      wsub;
      s_d      = s_q;
      wsub     = 8'h00;
      acc_we   = 1'b0;
      acc_wd   = 10'h000;
      white_we = 1'b0;
      white_wd = 6'h00;
      tot      = 10'h000;
      wavg     = 8'h00;
      nmax     = s_q.wmax;
      wref     = 6'h00;
      s_d.sv   = 1'b0;
      s_d.page_q = page_active;
      is_dummy = s_q.in_line && pix_valid && (s_q.idx < `DUMMY_PIX);
      is_img   = s_q.in_line && pix_valid && (s_q.idx >= `DUMMY_PIX);
      last_pix = is_img && (s_q.idx == `LINE_PIX - 9'd1);

      // line framing; pixels past the line end are dropped
      if (line_start)
      begin
         s_d.in_line = 1'b1;
         s_d.idx     = 9'h000;
         s_d.blk_sum = 13'h0000;
      end
      else if (pix_valid && s_q.in_line)
      begin
         s_d.idx = s_q.idx + 9'd1;
         if (last_pix)
            s_d.in_line = 1'b0;
      end

      // dummy pixels summed, not passed on
      if (is_dummy)
         s_d.blk_sum = s_q.blk_sum + {5'h00, pix_data};
      // average taken at the last dummy
      if (is_dummy && (s_q.idx == `DUMMY_PIX - 9'd1))
         s_d.blk_avg = 8'((s_q.blk_sum + {5'h00, pix_data}) >> `DUMMY_SHIFT);

      // a setting change outside a capture voids stored shading
      if (setting_change)
         s_d.shade_ok = 1'b0;

      unique case (s_q.st)
         ST_IDLE:
         begin
            // levels only follow the inputs between pages
            s_d.wlev = white_streak_level;
            s_d.dlev = dark_streak_level;
            if (page_active)
               s_d.st = ST_SCAN;
            // capture refused while a page runs
            else if (shade_start)
            begin
               s_d.st       = ST_ACQ;
               s_d.line_cnt = 3'h0;
               s_d.wmax     = 8'h00;
               s_d.shade_ok = 1'b0;
               s_d.in_line  = 1'b0;
            end
         end
         ST_ACQ:
         begin
            // accumulate white plate lines per pixel
            if (is_img)
            begin
               tot    = (s_q.line_cnt == 3'h0) ? {2'b00, pix_data}
                                               : acc_mem[img_idx] + {2'b00, pix_data};
               acc_we = 1'b1;
               acc_wd = tot;
               if (s_q.line_cnt == `SHADE_LINES - 3'h1)
               begin
                  wavg     = 8'(tot >> `SHADE_SHIFT);
                  // store only the upper six bits
                  white_we = 1'b1;
                  white_wd = wavg[7:2];
                  if (wavg > nmax)
                     nmax = wavg;
                  s_d.wmax = nmax;
               end
            end
            if (last_pix)
            begin
               s_d.line_cnt = s_q.line_cnt + 3'h1;
               if (s_q.line_cnt == `SHADE_LINES - 3'h1)
               begin
                  // peak at or under limit is a fault
                  s_d.lamp_fault = (nmax <= `LAMP_MIN);
                  // fresh shading ready for the next page
                  s_d.shade_ok   = 1'b1;
                  s_d.st         = ST_IDLE;
               end
            end
         end
         ST_SCAN:
         begin
            if (is_img)
            begin
               // both corrections on every image pixel
               // a function result cannot be part-selected, so go through a temporary
               wsub   = sub_sat({white_mem[img_idx], 2'b00}, s_q.blk_avg);
               wref   = wsub[7:2];
               s_d.sp    = gain(sub_sat(pix_data, s_q.blk_avg), wref);
               s_d.sv    = 1'b1;
               s_d.sreal = 1'b1;
            end
            // bubbles push the last pixels out of the erase window
            if (last_pix)
               s_d.flush = `FLUSH_CNT;
            else if (s_q.flush != 4'h0 && !is_img)
            begin
               s_d.flush = s_q.flush - 4'h1;
               s_d.sv    = 1'b1;
               s_d.sreal = 1'b0;
               s_d.sp    = 8'h00;
            end
            if (!page_active && s_q.page_q)
            begin
               // page done, shading must be retaken
               s_d.shade_ok = 1'b0;
               s_d.st       = ST_IDLE;
               s_d.flush    = 4'h0;
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.wlev <= `LEVEL_RESET;
         s_q.dlev <= `LEVEL_RESET;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------------
   // shading stores
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (acc_we)
         acc_mem[img_idx] <= acc_wd;
      if (white_we)
         white_mem[img_idx] <= white_wd;
   end

   // ------------------------------------------------------------------
   // streak erase stage
   // ------------------------------------------------------------------
   assign lk.in_valid  = s_q.sv;
   assign lk.in_pix    = s_q.sp;
   assign lk.in_real   = s_q.sreal;
   assign lk.white_lvl = s_q.wlev;
   assign lk.dark_lvl  = s_q.dlev;

   streak_erase u_erase
   (
      .clk    (clk),
      .arst_n (arst_n),
      .lk     (lk)
   );

   // outputs: erase stage outputs are its own flops
   assign out_valid       = lk.out_valid;
   assign out_pix         = lk.out_pix;
   assign lamp_fault_code = s_q.lamp_fault;
   assign shading_needed  = !s_q.shade_ok;
   assign shade_busy      = (s_q.st == ST_ACQ);

endmodule : scan_shading_line_erase

// [test/scan_shading_line_erase_sva.sv]
// checker on the ports of the shading core
// assumes one clock, async low reset, lines of 288 pixels
`timescale 1ns/1ps
module scan_shading_line_erase_sva
   import scan_shading_pkg::*;
(
   input wire logic   clk,
   input wire logic   arst_n,
   input wire logic   line_start,
   input wire logic   pix_valid,
   input wire pixel_t pix_data,
   input wire logic   shade_start,
   input wire logic   page_active,
   input wire logic   setting_change,
   input wire level_t white_streak_level,
   input wire level_t dark_streak_level,
   input wire logic   out_valid,
   input wire pixel_t out_pix,
   input wire logic   lamp_fault_code,
   input wire logic   shading_needed,
   input wire logic   shade_busy
);
   localparam int CAP_MIN = 1152; // four whole lines
   logic [11:0] busy_cnt_q;

   // ----
   // capture length counter
   // ----
   // counts busy cycles, cleared once idle again
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         busy_cnt_q <= 12'h000;
      else if (shade_busy)
         busy_cnt_q <= busy_cnt_q + 12'h001;
      else
         busy_cnt_q <= 12'h000;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_take; shade_start && !shade_busy && !page_active; endsequence
   sequence s_end; $fell(shade_busy); endsequence

   property p_take; s_take |=> shade_busy; endproperty
   property p_idle; !shade_start && !shade_busy |=> !shade_busy; endproperty
   property p_page_refuse; page_active && !shade_busy |=> !shade_busy; endproperty
   property p_cap_len; s_end |-> busy_cnt_q >= CAP_MIN; endproperty
   property p_cap_ok; s_end |-> !shading_needed; endproperty
   property p_lamp_hold; !$fell(shade_busy) |-> $stable(lamp_fault_code); endproperty
   property p_page_need; $fell(page_active) |-> ##[1:2] shading_needed; endproperty
   property p_change_need; setting_change && !shade_busy |-> ##[1:2] shading_needed; endproperty
   property p_need_hold; shading_needed && !shade_busy |=> shading_needed; endproperty

   a_take: assert property (p_take) else $error("capture not started");
   a_idle: assert property (p_idle) else $error("capture without request");
   a_page_refuse: assert property (p_page_refuse) else $error("capture in page");
   a_cap_len: assert property (p_cap_len) else $error("capture too short");
   a_cap_ok: assert property (p_cap_ok) else $error("shading not marked done");
   a_lamp_hold: assert property (p_lamp_hold) else $error("lamp flag moved");
   a_page_need: assert property (p_page_need) else $error("page end kept shading");
   a_change_need: assert property (p_change_need) else $error("change kept shading");
   a_need_hold: assert property (p_need_hold) else $error("need flag dropped");
endmodule : scan_shading_line_erase_sva

bind scan_shading_line_erase scan_shading_line_erase_sva chk
(
   .clk, .arst_n, .line_start, .pix_valid, .pix_data, .shade_start, .page_active,
   .setting_change, .white_streak_level, .dark_streak_level, .out_valid, .out_pix,
   .lamp_fault_code, .shading_needed, .shade_busy
);

// [test/ccd_front_end.sv]
// behavioural sensor front end sending one line per task call
// assumes the caller runs between lines only
`timescale 1ns/1ps
module ccd_front_end
   import scan_shading_pkg::*;
(
   input  wire logic clk,
   output logic      line_start,
   output logic      pix_valid,
   output pixel_t    pix_data
);
   logic active = 1'b0;

   initial
   begin
      line_start = 1'b0;
      pix_valid = 1'b0;
      pix_data = 8'h00;
   end

   // released data bus keeps toggling so stale data never matches
   always @(negedge clk)
      if (!active)
         pix_data <= ~pix_data;

   // ----
   // line sender
   // ----
   task automatic send_line(input pixel_t blk, input pixel_t bg, input pixel_t sv,
                            input int ss, input int sw, input bit slow);
      @(posedge clk);
      active = 1'b1;
      @(negedge clk);
      line_start = 1'b1;
      @(negedge clk);
      line_start = 1'b0;
      for (int i = 0; i < 288; i++)
      begin
         // slow mode: a gap every fifty pixels
         if (slow && i % 50 == 49)
         begin
            pix_valid = 1'b0;
            pix_data = ~pix_data;
            @(negedge clk);
         end
         pix_valid = 1'b1;
         pix_data = (i < 32) ? blk : ((i - 32 >= ss && i - 32 < ss + sw) ? sv : bg);
         @(negedge clk);
      end
      pix_valid = 1'b0;
      @(posedge clk);
      active = 1'b0;
      // flush room before the next line
      repeat (16) @(negedge clk);
   endtask : send_line
endmodule : ccd_front_end

// [test/tb_top.sv]
// self-checking bench for the shading and streak erase core
// assumes the checker is bound and the front end model drives pixels
`timescale 1ns/1ps
module tb_top;
   import scan_shading_pkg::*;
   localparam int BLK = 16;
   localparam int WHT = 208;
   logic   clk = 1'b0;
   logic   arst_n = 1'b0;
   logic   line_start, pix_valid, shade_start = 1'b0, page_active = 1'b0;
   logic   setting_change = 1'b0;
   pixel_t pix_data, out_pix;
   level_t white_streak_level = 2'h1, dark_streak_level = 2'h1;
   logic   out_valid, lamp_fault_code, shading_needed, shade_busy;
   int     mismatches = 0, n_checks = 0, cycles = 0, n_out = 0;
   pixel_t got [0:255];

   always #25 clk = ~clk;

   scan_shading_line_erase dut (.clk, .arst_n, .line_start, .pix_valid, .pix_data,
      .shade_start, .page_active, .setting_change, .white_streak_level,
      .dark_streak_level, .out_valid, .out_pix, .lamp_fault_code, .shading_needed,
      .shade_busy);
   ccd_front_end fe (.clk, .line_start, .pix_valid, .pix_data);

   // output capture and hang guard; sampled mid-cycle where outputs are settled
   always @(negedge clk)
   begin
      cycles++;
      if (out_valid === 1'b1 && n_out < 256)
         got[n_out] = out_pix;
      if (out_valid === 1'b1)
         n_out++;
      if (cycles == 40000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // black offset then white gain, saturating at full white
   function automatic pixel_t corr(input int p);
      int v;
      int q;
      v = (p > BLK) ? p - BLK : 0;
      q = v * 64 / (((WHT / 4) * 4 - BLK) / 4);
      corr = (q > 255) ? 8'hFF : 8'(q);
   endfunction : corr

   task automatic capture(input pixel_t w);
      @(negedge clk);
      shade_start = 1'b1;
      @(negedge clk);
      shade_start = 1'b0;
      check("busy_on", shade_busy, 1);
      repeat (4) fe.send_line(8'(BLK), w, w, 0, 0, 1);
      check("busy_off", shade_busy, 0);
      check("need_off", shading_needed, 0);
      check("lamp", lamp_fault_code, w <= 8'h40);
   endtask : capture

   task automatic scan(input level_t wl, input level_t dl, input pixel_t sv, input int sw,
                       input bit erased, input level_t wl_mid);
      pixel_t e;
      capture(8'(WHT));
      white_streak_level = wl;
      dark_streak_level = dl;
      n_out = 0;
      @(negedge clk);
      page_active = 1'b1;
      @(negedge clk);
      // level change and capture request inside a page have no effect
      white_streak_level = wl_mid;
      shade_start = 1'b1;
      @(negedge clk);
      shade_start = 1'b0;
      check("busy_page", shade_busy, 0);
      fe.send_line(8'(BLK), 8'h70, sv, 100, sw, 0);
      page_active = 1'b0;
      check("count", 9'(n_out), 9'd256);
      for (int i = 0; i < 256; i++)
      begin
         e = (i >= 100 && i < 100 + sw && !erased) ? corr(sv) : corr(8'h70);
         check("pix", got[i], e);
      end
      repeat (2) @(negedge clk);
      check("need_page", shading_needed, 1);
   endtask : scan

   // ----
   // main sequence
   // ----
   initial
   begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      check("need_rst", shading_needed, 1);
      check("lamp_rst", lamp_fault_code, 0);
      check("busy_rst", shade_busy, 0);
      capture(8'h40);
      capture(8'(WHT));
      setting_change = 1'b1;
      @(negedge clk);
      setting_change = 1'b0;
      @(negedge clk);
      check("need_chg", shading_needed, 1);
      scan(1, 1, 8'h70, 0, 0, 1);
      scan(1, 0, 8'hA0, 1, 0, 2);
      scan(2, 0, 8'hA0, 6, 1, 2);
      scan(2, 0, 8'hA0, 7, 0, 2);
      scan(0, 0, 8'hA0, 1, 0, 0);
      scan(1, 1, 8'h10, 4, 1, 1);
      scan(1, 2, 8'h10, 5, 0, 1);
      scan(1, 3, 8'h40, 6, 1, 1);
      scan(1, 2, 8'h40, 1, 0, 1);
      scan(1, 0, 8'h10, 1, 0, 1);
      report_and_stop();
   end
endmodule : tb_top
